/* dv/asp_codec.sv */
// file: behavioural audio codec at the far side of the serial pins
`timescale 1ns/1ps
module asp_codec (
    // link control
    input  wire logic        clk_en_in,
    input  wire logic [15:0] tx_word_in,
    // serial pins as resolved on the board
    input  wire logic        sck_in,
    input  wire logic        fs_in,
    input  wire logic        sd_in,
    output logic             sck_out,
    output logic             fs_out,
    output logic             sd_out,
    // received words
    output logic      [15:0] rx_word_out,
    output int               rx_count_out
);
    int          bit_n;
    logic [15:0] rx_sh;
    logic [15:0] tx_sh;
    logic        fs_q;
    logic        load_q;
    // ----------------------------------------------------------------
    // clock and sync source, used only when the port is a slave
    // ----------------------------------------------------------------
    initial begin
        {sck_out, fs_out, sd_out, fs_q, load_q} = 5'h0;
        {rx_sh, tx_sh, rx_word_out} = 48'h0;
        bit_n = 0;
        rx_count_out = 0;
        #13;
        forever begin
            #200;
            if (clk_en_in) begin
                sck_out = ~sck_out;
                if (!sck_out) begin
                    bit_n = (bit_n + 1) % 16;
                    if (bit_n == 0) begin
                        fs_out = ~fs_out;
                    end
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // data: msb first, new word one bit after the sync change
    // ----------------------------------------------------------------
    always @(posedge sck_in) begin
        rx_sh = {rx_sh[14:0], sd_in};
        if (fs_in !== fs_q) begin
            rx_word_out = rx_sh;
            rx_count_out = rx_count_out + 1;
            load_q = 1'b1;
        end
        fs_q = fs_in;
    end
    always @(negedge sck_in) begin
        tx_sh = load_q ? tx_word_in : {tx_sh[14:0], 1'b0};
        load_q = 1'b0;
        sd_out = tx_sh[15];
    end
endmodule : asp_codec

/* dv/asp_port_test.sv */
// file: self-checking testbench of the audio serial port
`timescale 1ns/1ps
module asp_port_test;
    logic        clk_in   = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic        c_en     = 1'b0;
    logic [15:0] c_tx     = 16'h1234;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sck_o, sck_oe_n, fs_o, fs_oe_n, mck, irq, c_sck, c_fs, c_sd;
    logic [1:0]  sd_o, sd_oe_n;
    logic [15:0] c_word;
    logic        mck_seen;
    int          c_cnt;
    int          checks     = 0;
    int          num_errors = 0;
    // ----------------------------------------------------------------
    // pin resolution, clock, design and partner
    // ----------------------------------------------------------------
    wire       sck_w = sck_oe_n ? c_sck : sck_o;
    wire       fs_w  = fs_oe_n ? c_fs : fs_o;
    wire [1:0] sd_w  = {sd_oe_n[1] ? ~sd_o[1] : sd_o[1], sd_oe_n[0] ? c_sd : sd_o[0]};
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    asp_port dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .sck_pin_in(sck_w), .sck_pin_out(sck_o),
        .sck_pin_oe_n_out(sck_oe_n), .fs_pin_in(fs_w), .fs_pin_out(fs_o),
        .fs_pin_oe_n_out(fs_oe_n), .mck_out(mck), .sd_pin_in(sd_w), .sd_pin_out(sd_o),
        .sd_pin_oe_n_out(sd_oe_n), .irq_out(irq));
    asp_codec partner (.clk_en_in(c_en), .tx_word_in(c_tx), .sck_in(sck_w), .fs_in(fs_w),
        .sd_in(sd_w[1]), .sck_out(c_sck), .fs_out(c_fs), .sd_out(c_sd),
        .rx_word_out(c_word), .rx_count_out(c_cnt));
    // ----------------------------------------------------------------
    // bus and checking tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd_v);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        rd_v = hrdata;
    endtask : bus
    task automatic chk(input logic [31:0] got, exp, mask, input string what);
        checks++;
        if ((got & mask) !== (exp & mask)) begin
            num_errors++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, a, d, t);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, mask);
        logic [31:0] t;
        bus(1'b0, a, 32'h0, t);
        chk(t, exp, mask, $sformatf("read at %h", a));
    endtask : rd
    task automatic poll(input logic [31:0] mask);
        logic [31:0] t;
        t = 32'h0;
        for (int i = 0; i < 3000 && (t & mask) == 32'h0; i++) begin
            bus(1'b0, asp_pkg::OFF_INTERRUPT_FLAG_SET, 32'h0, t);
        end
        chk(t, mask, mask, "flag wait");
    endtask : poll
    task automatic next_word();
        int c;
        c = c_cnt;
        for (int i = 0; i < 4000 && c_cnt == c; i++) @(posedge clk_in);
    endtask : next_word
    task automatic rx_expect(input logic [15:0] exp);
        logic [31:0] t;
        // drop words that may span a reconfiguration
        repeat (2) begin
            poll(32'h1);
            bus(1'b0, asp_pkg::OFF_DATA0, 32'h0, t);
        end
        poll(32'h1);
        rd(asp_pkg::OFF_DATA0, {16'h0, exp}, 32'hFFFF);
        rd(asp_pkg::OFF_INTERRUPT_FLAG_SET, 32'h0, 32'h1);
    endtask : rx_expect
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (80000) @(posedge clk_in);
        num_errors++;
        $display("FAIL %0t watchdog expired", $time);
        complete_run();
    end
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rd(asp_pkg::OFF_CTRL, 32'h0, 32'hFFFF_FFFF);
        rd(asp_pkg::OFF_CLKDIV, {24'h0, asp_pkg::CLKDIV_RESET}, 32'hFF);
        rd(8'h20, 32'h0, 32'hFFFF_FFFF);
        wr(asp_pkg::OFF_CTRL, 32'h1);
        wr(asp_pkg::OFF_SERCTRL1, 32'h3);
        wr(asp_pkg::OFF_SERCTRL0, 32'h1);
        chk({30'h0, sck_oe_n, fs_oe_n}, 32'h0, 32'h3, "master drives clocks");
        mck_seen = mck;
        @(posedge clk_in);
        chk({30'h0, mck, hresp}, {30'h0, ~mck_seen, 1'b0}, 32'h3, "master clock");
        poll(32'h20);
        wr(asp_pkg::OFF_DATA1, 32'hA5C3);
        rd(asp_pkg::OFF_INTERRUPT_FLAG_SET, 32'h0, 32'h20);
        for (int i = 0; i < 8 && c_word !== 16'hA5C3; i++) next_word();
        chk({16'h0, c_word}, 32'hA5C3, 32'hFFFF, "sent word");
        next_word();
        chk({16'h0, c_word}, 32'h0, 32'hFFFF, "zero on underrun");
        rd(asp_pkg::OFF_INTERRUPT_FLAG_SET, 32'h80, 32'h80);
        wr(asp_pkg::OFF_INTERRUPT_FLAG_SET, 32'h80);
        rd(asp_pkg::OFF_INTERRUPT_FLAG_SET, 32'h0, 32'h80);
        wr(asp_pkg::OFF_SERCTRL1, 32'h0);
        wr(asp_pkg::OFF_SERCTRL1, 32'h7);
        wr(asp_pkg::OFF_DATA1, 32'h5AA5);
        poll(32'h20);
        wr(asp_pkg::OFF_DATA1, 32'h5AA5);
        poll(32'h20);
        for (int i = 0; i < 4; i++) begin
            next_word();
            chk({16'h0, c_word}, 32'h5AA5, 32'hFFFF, "repeat on underrun");
        end
        rx_expect(16'h1234);
        poll(32'h4);
        wr(asp_pkg::OFF_INTERRUPT_FLAG_SET, 32'h4);
        rd(asp_pkg::OFF_INTERRUPT_FLAG_SET, 32'h0, 32'h4);
        poll(32'h1);
        wr(asp_pkg::OFF_INTMASK, 32'h1);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h1, 32'h1, "irq raised");
        wr(asp_pkg::OFF_INTMASK, 32'h0);
        repeat (2) @(posedge clk_in);
        chk({31'h0, irq}, 32'h0, 32'h1, "irq masked");
        wr(asp_pkg::OFF_SERCTRL0, 32'h0);
        wr(asp_pkg::OFF_SERCTRL0, 32'h9);
        rx_expect(16'h5AA5);
        wr(asp_pkg::OFF_SERCTRL0, 32'h0);
        wr(asp_pkg::OFF_SERCTRL0, 32'h1);
        rx_expect(16'h1234);
        wr(asp_pkg::OFF_CTRL, 32'h9);
        for (int i = 0; i < 2000 && fs_o !== 1'b0; i++) @(posedge clk_in);
        for (int i = 0; i < 2000 && fs_o !== 1'b1; i++) @(posedge clk_in);
        chk({31'h0, fs_o}, 32'h1, 32'h1, "tdm sync seen");
        repeat (12) @(posedge clk_in);
        chk({31'h0, fs_o}, 32'h0, 32'h1, "tdm sync is a pulse");
        wr(asp_pkg::OFF_CTRL, 32'h0);
        wr(asp_pkg::OFF_CTRL, 32'h3);
        repeat (20) @(posedge clk_in);
        chk({28'h0, sck_oe_n, fs_oe_n, sd_oe_n}, 32'h3, 32'hF, "controller pins");
        wr(asp_pkg::OFF_CTRL, 32'h0);
        wr(asp_pkg::OFF_CTRL, 32'h7);
        c_en <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk({28'h0, sck_oe_n, fs_oe_n, 2'h0}, 32'hC, 32'hC, "slave pins");
        next_word();
        next_word();
        rx_expect(16'h1234);
        complete_run();
    end
endmodule : asp_port_test

/* rtl/asp_pkg.sv */
// package: register map, field layout and types of the audio serial port
package asp_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_CLKDIV   = 8'h04;
    localparam logic [7:0] OFF_SERCTRL0 = 8'h08;
    localparam logic [7:0] OFF_SERCTRL1 = 8'h0C;
    localparam logic [7:0] OFF_INTERRUPT_FLAG_SET  = 8'h10;
    localparam logic [7:0] OFF_INTMASK  = 8'h14;
    localparam logic [7:0] OFF_DATA0    = 8'h18;
    localparam logic [7:0] OFF_DATA1    = 8'h1C;

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    // control: [0] enable, [2:1] mode, [3] tdm format
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_TDM_BIT  = 3;
    // serializer control: [0] enable, [1] transmit, [2] repeat, [3] loop
    localparam int SC_EN_BIT   = 0;
    localparam int SC_TX_BIT   = 1;
    localparam int SC_SAME_BIT = 2;
    localparam int SC_LOOP_BIT = 3;
    // flags: [m] rx ready, [2+m] rx overrun, [4+m] tx ready, [6+m] tx underrun
    localparam int FLG_RXRDY = 0;
    localparam int FLG_RXOR  = 2;
    localparam int FLG_TXRDY = 4;
    localparam int FLG_TXUR  = 6;

    localparam logic [7:0] CLKDIV_RESET = 8'h04;
    localparam logic [4:0] SLOT_BITS    = 5'h10;
    localparam logic [2:0] TDM_SLOTS    = 3'h4;

    typedef enum logic [1:0] {
        ASP_MODE_MASTER = 2'h0,
        ASP_MODE_CTRLR  = 2'h1,
        ASP_MODE_SLAVE  = 2'h3
    } asp_mode_e;

    typedef struct packed {
        logic en;
        logic tx;
        logic same;
        logic loop;
    } asp_serctrl_s;

endpackage : asp_pkg

/* rtl/asp_port.sv */
// module: audio serial port with two serializers and an ahb-lite slave
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// R1: received word stored, receive ready set
// R2: reading data register clears receive ready
// R3: unread word overwritten sets overrun, write-one clears
// R4: transmit ready set while holding register empty
// R5: any data write clears transmit ready
// R6: shift needed without new word sets underrun
// R7: underrun sends zero or repeats slot word
// R8: one data register serves all slots
// R9: master and controller drive clock, sync
// R10: controller mode keeps serializers disabled
// R11: slave mode takes clock, sync from outside
// R12: sync is word select or tdm pulse
// R13: msb first, one clock after sync edge
// R14: loop takes other serializer's output
// R15: software pairs looping receiver with transmitter
// R16: loop cleared reconnects own data pin
// R17: software disables serializer before reconfiguring
// R18: slave clock, sync synchronized; edge-sampled data
module asp_port (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // serial pins
    input  wire logic        sck_pin_in,
    output logic             sck_pin_out,
    output logic             sck_pin_oe_n_out,
    input  wire logic        fs_pin_in,
    output logic             fs_pin_out,
    output logic             fs_pin_oe_n_out,
    output logic             mck_out,
    input  wire logic [1:0]  sd_pin_in,
    output logic      [1:0]  sd_pin_out,
    output logic      [1:0]  sd_pin_oe_n_out,
    // interrupt
    output logic             irq_out
);

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic        ctrl_en_q;
    logic [1:0]  mode_q;
    logic        tdm_q;
    logic [7:0]  clkdiv_q;
    logic [3:0]  serctrl_q [2];
    logic [7:0]  flag_q;
    logic [7:0]  mask_q;
    logic [31:0] data_q [2];
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [7:0]  rd_data_flag_d;
    logic [31:0] rd_mux;

    wire       addr_ok  = hsel_in && hready_in && htrans_in[1];
    wire       wr_phase = wr_pend_q;
    wire       rd_now   = addr_ok && !hwrite_in;
    wire [7:0] ra       = haddr_in[7:0];
    wire [1:0] rd_data  = {rd_now && ra == asp_pkg::OFF_DATA1,
                           rd_now && ra == asp_pkg::OFF_DATA0};
    wire [1:0] wr_data  = {wr_phase && wr_addr_q == asp_pkg::OFF_DATA1,
                           wr_phase && wr_addr_q == asp_pkg::OFF_DATA0};
    wire       wr_flag  = wr_phase && wr_addr_q == asp_pkg::OFF_INTERRUPT_FLAG_SET;
    wire [7:0] flag_clr = wr_flag ? (hwdata_in[7:0] & 8'hCC) : 8'h00;
    wire       is_ctrlr = mode_q == asp_pkg::ASP_MODE_CTRLR;
    wire       is_slave = mode_q == asp_pkg::ASP_MODE_SLAVE;

    assign rd_mux = (ra == asp_pkg::OFF_CTRL)     ? {28'h0, tdm_q, mode_q, ctrl_en_q} :
                    (ra == asp_pkg::OFF_CLKDIV)   ? {24'h0, clkdiv_q} :
                    (ra == asp_pkg::OFF_SERCTRL0) ? {28'h0, serctrl_q[0]} :
                    (ra == asp_pkg::OFF_SERCTRL1) ? {28'h0, serctrl_q[1]} :
                    (ra == asp_pkg::OFF_INTERRUPT_FLAG_SET)  ? {24'h0, flag_q} :
                    (ra == asp_pkg::OFF_INTMASK)  ? {24'h0, mask_q} :
                    (ra == asp_pkg::OFF_DATA0)    ? data_q[0] :
                    (ra == asp_pkg::OFF_DATA1)    ? data_q[1] : 32'h0;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_pend_q  <= 1'b0;
            wr_addr_q  <= 8'h00;
            hrdata_out <= 32'h0;
        end else begin
            wr_pend_q <= addr_ok && hwrite_in;
            wr_addr_q <= ra;
            if (rd_now) begin
                hrdata_out <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_en_q <= 1'b0;
            mode_q    <= 2'h0;
            tdm_q     <= 1'b0;
            clkdiv_q  <= asp_pkg::CLKDIV_RESET;
            mask_q    <= 8'h00;
        end else if (wr_phase) begin
            case (wr_addr_q)
                asp_pkg::OFF_CTRL: begin
                    ctrl_en_q <= hwdata_in[asp_pkg::CTRL_EN_BIT];
                    mode_q    <= hwdata_in[asp_pkg::CTRL_MODE_LSB +: 2];
                    tdm_q     <= hwdata_in[asp_pkg::CTRL_TDM_BIT];
                end
                asp_pkg::OFF_CLKDIV:  clkdiv_q <= hwdata_in[7:0];
                asp_pkg::OFF_INTMASK: mask_q   <= hwdata_in[7:0];
                default: ;
            endcase
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // ------------------------------------------------------------
    // clock generation and pin synchronizers
    // ------------------------------------------------------------
    logic [7:0] div_cnt_q;
    logic       gen_sck_q;
    logic       gen_sck_fall;
    logic [1:0] sck_sync_q;
    logic [1:0] fs_sync_q;
    logic [1:0] sd0_sync_q;
    logic [1:0] sd1_sync_q;
    logic       sck_prev_q;
    logic       fs_prev_q;
    logic       fs_seen_q;
    logic       gen_fs_q;
    logic [4:0] bit_q;
    logic [2:0] slot_q;

    wire gen_tick  = ctrl_en_q && !is_slave && div_cnt_q == clkdiv_q;
    assign gen_sck_fall = gen_tick && gen_sck_q;
    wire ext_sck   = sck_sync_q[1];
    wire ext_fs    = fs_sync_q[1];
    wire ext_rise  = ext_sck && !sck_prev_q;
    wire ext_fall  = !ext_sck && sck_prev_q;
    // shift on falling edge, sample on rising edge
    wire sh_edge   = is_slave ? (ctrl_en_q && ext_fall) : gen_sck_fall;          // [R18]
    wire smp_edge  = is_slave ? (ctrl_en_q && ext_rise) : (gen_tick && !gen_sck_q); // [R18]
    wire fs_now    = is_slave ? ext_fs : gen_fs_q;
    wire fs_chg    = is_slave ? (fs_now != fs_prev_q) : 1'b0;
    wire [4:0] last_bit = asp_pkg::SLOT_BITS - 5'h01;
    // two slots in word-select format, four in tdm
    wire [2:0] slot_last = tdm_q ? asp_pkg::TDM_SLOTS - 3'h1 : 3'h1;
    wire fs_seen   = tdm_q ? (fs_now && !fs_prev_q) : fs_chg;
    // slave: msb follows one clock after the sync edge, so the slot turns one bit later
    wire slot_end  = is_slave ? fs_seen_q : bit_q == last_bit;                   // [R13]

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sck_sync_q <= 2'h0;
            fs_sync_q  <= 2'h0;
            sd0_sync_q <= 2'h0;
            sd1_sync_q <= 2'h0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_sync_q <= {sck_sync_q[0], sck_pin_in};                       // [R11] [R18]
            fs_sync_q  <= {fs_sync_q[0], fs_pin_in};
            sd0_sync_q <= {sd0_sync_q[0], sd_pin_in[0]};
            sd1_sync_q <= {sd1_sync_q[0], sd_pin_in[1]};
            sck_prev_q <= ext_sck;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_cnt_q <= 8'h00;
            gen_sck_q <= 1'b0;
            mck_out   <= 1'b0;
        end else begin
            mck_out <= ctrl_en_q && !is_slave && !mck_out;                    // [R9]
            if (gen_tick || !ctrl_en_q || is_slave) begin
                div_cnt_q <= 8'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
            if (gen_tick) begin
                gen_sck_q <= !gen_sck_q;
            end else if (!ctrl_en_q || is_slave) begin
                gen_sck_q <= 1'b0;
            end
        end
    end

    // bit and slot counters; sync changes one bit before the msb
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bit_q     <= 5'h00;
            slot_q    <= 3'h0;
            gen_fs_q  <= 1'b0;
            fs_prev_q <= 1'b0;
            fs_seen_q <= 1'b0;
        end else begin
            if (sh_edge) begin
                fs_prev_q <= fs_now;
                fs_seen_q <= is_slave && fs_seen;                               // [R18]
                if (slot_end) begin
                    bit_q  <= 5'h00;
                    slot_q <= (slot_q < slot_last) ? slot_q + 3'h1 : 3'h0;       // [R7]
                end else begin
                    bit_q <= bit_q + 5'h01;
                end
                if (!is_slave) begin
                    // toggled at bit 14 so sync leads msb by one clock [R13] [R12]
                    if (bit_q == last_bit - 5'h01) begin
                        gen_fs_q <= tdm_q ? (slot_q == asp_pkg::TDM_SLOTS - 3'h1) : !gen_fs_q;
                    end else if (tdm_q) begin
                        gen_fs_q <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sck_pin_out      <= 1'b0;
            sck_pin_oe_n_out <= 1'b1;
            fs_pin_out       <= 1'b0;
            fs_pin_oe_n_out  <= 1'b1;
        end else begin
            sck_pin_out      <= gen_sck_q;                                      // [R9]
            fs_pin_out       <= gen_fs_q;
            sck_pin_oe_n_out <= !(ctrl_en_q && !is_slave);                      // [R11]
            fs_pin_oe_n_out  <= !(ctrl_en_q && !is_slave);
        end
    end

    // ------------------------------------------------------------
    // serializers
    // ------------------------------------------------------------
    logic [31:0] sh_q   [2];
    logic [31:0] prev_q [2][8];
    logic [1:0]  full_q;
    logic [1:0]  sd_out_q;
    logic [1:0]  sd_oe_n_q;
    logic [1:0]  rx_done;
    logic [1:0]  tx_load;
    logic [1:0]  ser_on;
    logic [1:0]  rx_bit;

    genvar m;
    generate
        for (m = 0; m < 2; m++) begin : g_ser
            asp_pkg::asp_serctrl_s sc;
            assign sc = asp_pkg::asp_serctrl_s'({serctrl_q[m][asp_pkg::SC_EN_BIT],
                                                 serctrl_q[m][asp_pkg::SC_TX_BIT],
                                                 serctrl_q[m][asp_pkg::SC_SAME_BIT],
                                                 serctrl_q[m][asp_pkg::SC_LOOP_BIT]});
            wire wr_sc  = wr_phase && wr_addr_q == (m == 0 ? asp_pkg::OFF_SERCTRL0
                                                           : asp_pkg::OFF_SERCTRL1);
            wire pin_in = (m == 0) ? sd0_sync_q[1] : sd1_sync_q[1];
            assign ser_on[m]  = sc.en && ctrl_en_q && !is_ctrlr;                 // [R10]
            assign rx_bit[m]  = sc.loop ? sd_out_q[1 - m] : pin_in;            // [R14] [R16]
            assign rx_done[m] = ser_on[m] && !sc.tx && sh_edge && slot_end;
            assign tx_load[m] = ser_on[m] && sc.tx && sh_edge && slot_end;
            wire [31:0] tx_word = full_q[m] ? data_q[m] :
                                  (sc.same ? prev_q[m][slot_q] : 32'h0);        // [R7]
            wire [31:0] rx_word = sh_q[m] << (6'h20 - {1'b0, asp_pkg::SLOT_BITS});

            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    serctrl_q[m] <= 4'h0;
                end else if (wr_sc) begin
                    serctrl_q[m] <= hwdata_in[3:0];
                end
            end

            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    sh_q[m]      <= 32'h0;
                    data_q[m]    <= 32'h0;
                    full_q[m]    <= 1'b0;
                    sd_out_q[m]  <= 1'b0;
                    sd_oe_n_q[m] <= 1'b1;
                end else begin
                    sd_oe_n_q[m] <= !(ser_on[m] && sc.tx);
                    if (tx_load[m]) begin
                        sh_q[m]            <= tx_word << (6'h20 - {1'b0, asp_pkg::SLOT_BITS});
                        prev_q[m][slot_q]  <= tx_word;
                        sd_out_q[m]        <= tx_word[asp_pkg::SLOT_BITS - 5'h01];  // [R13]
                    end else if (ser_on[m] && sc.tx && sh_edge) begin
                        sd_out_q[m] <= sh_q[m][30];
                        sh_q[m]     <= {sh_q[m][30:0], 1'b0};
                    end else if (ser_on[m] && !sc.tx && smp_edge) begin
                        sh_q[m] <= {sh_q[m][30:0], rx_bit[m]};                   // [R13]
                    end
                    if (rx_done[m]) begin
                        data_q[m] <= rx_word >> (6'h20 - {1'b0, asp_pkg::SLOT_BITS}); // [R1] [R8]
                    end else if (wr_data[m]) begin
                        data_q[m] <= hwdata_in;                                   // [R8]
                    end
                    // a write in the load cycle keeps its word for the next slot
                    if (wr_data[m]) begin
                        full_q[m] <= 1'b1;                                        // [R5]
                    end else if (tx_load[m]) begin
                        full_q[m] <= 1'b0;                                        // [R4]
                    end
                end
            end
        end
    endgenerate

    assign sd_pin_out      = sd_out_q;
    assign sd_pin_oe_n_out = sd_oe_n_q;

    // ------------------------------------------------------------
    // flags and interrupt
    // ------------------------------------------------------------
    always_comb begin
        rd_data_flag_d = flag_q & ~flag_clr;
        for (int k = 0; k < 2; k++) begin
            if (rd_data[k]) begin
                rd_data_flag_d[asp_pkg::FLG_RXRDY + k] = 1'b0;                   // [R2]
            end
            if (rx_done[k]) begin
                rd_data_flag_d[asp_pkg::FLG_RXRDY + k] = 1'b1;                   // [R1]
                if (flag_q[asp_pkg::FLG_RXRDY + k] && !rd_data[k]) begin
                    rd_data_flag_d[asp_pkg::FLG_RXOR + k] = 1'b1;                // [R3]
                end
            end
            rd_data_flag_d[asp_pkg::FLG_TXRDY + k] =
                ser_on[k] && serctrl_q[k][asp_pkg::SC_TX_BIT] && !full_q[k]
                && !wr_data[k];                                                  // [R4] [R5]
            if (tx_load[k] && !full_q[k]) begin
                rd_data_flag_d[asp_pkg::FLG_TXUR + k] = 1'b1;                    // [R6]
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flag_q  <= 8'h00;
            irq_out <= 1'b0;
        end else begin
            flag_q  <= rd_data_flag_d;
            irq_out <= |(rd_data_flag_d & mask_q);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_rx_ready_set: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
        rx_done[0] |=> flag_q[asp_pkg::FLG_RXRDY]) else $error("rx ready not set");
    a_rx_read_clr: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
        rd_data[0] && !rx_done[0] |=> !flag_q[asp_pkg::FLG_RXRDY])
        else $error("rx ready not cleared by read");
    a_overrun_set: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
        rx_done[0] && flag_q[asp_pkg::FLG_RXRDY] && !rd_data[0]
        |=> flag_q[asp_pkg::FLG_RXOR]) else $error("overrun missed");
    a_tx_write_clr: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
        wr_data[1] |=> !flag_q[asp_pkg::FLG_TXRDY + 1]) else $error("tx ready stays after write");
    a_underrun_set: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R6]
        tx_load[1] && !full_q[1] |=> flag_q[asp_pkg::FLG_TXUR + 1]) else $error("underrun missed");
    a_ctrlr_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R10]
        is_ctrlr |-> ser_on == 2'h0) else $error("serializer active in controller mode");
    a_slave_inputs: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R11]
        is_slave ##1 is_slave |-> sck_pin_oe_n_out && fs_pin_oe_n_out)
        else $error("clock pins driven in slave mode");
    a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $past(|(rd_data_flag_d & mask_q)) == irq_out) else $error("irq mismatch");

endmodule : asp_port
